// ### ibus_checker.sv
// concurrent checks on the command responder ports
`timescale 1ns/1ps
`default_nettype none
module ibus_checker (
    input wire logic hclk,               // clock
    input wire logic hresetn,            // reset, active low
    input wire logic ren_n,              // remote enable pin
    input wire logic ifc_n,              // interface clear pin
    input wire logic srq_oe_n,           // service request pull
    input wire logic remote_indicator,   // remote lamp
    input wire logic talker_indicator,   // talk lamp
    input wire logic listener_indicator, // listen lamp
    input wire logic srq_indicator,      // request lamp
    input wire logic keys_enable,        // panel keys usable
    input wire logic meas_abort,         // abort pulse
    input wire logic meas_start,         // start pulse
    input wire logic output_cancel,      // cancel pulse
    input wire logic gate_reset,         // gate pulse
    input wire logic display_blank,      // blank pulse
    input wire logic errors_clear        // errors pulse
);
    // ************************************************
    // interface state and action checks
    // ************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    reset_flags_a: assert property ($rose(hresetn) |->
        !remote_indicator && !talker_indicator && !listener_indicator)
        else $error("flags not clear after reset");
    ren_off_a: assert property (ren_n [*6] |-> !remote_indicator)
        else $error("remote held without remote enable");
    ifc_idle_a: assert property (!ifc_n [*6] |->
        !talker_indicator && !listener_indicator)
        else $error("addressing kept during interface clear");
    remote_keys_a: assert property (remote_indicator [*2] |-> !keys_enable)
        else $error("keys usable in remote");
    get_pair_a: assert property (meas_start |-> meas_abort && !output_cancel)
        else $error("start without abort");
    clear_group_a: assert property (output_cancel |-> meas_abort &&
        gate_reset && display_blank && errors_clear)
        else $error("clear actions incomplete");
    pulse_one_a: assert property (meas_abort |=> !meas_abort)
        else $error("abort pulse too long");
    srq_lamp_a: assert property (!srq_oe_n [*3] |-> srq_indicator)
        else $error("request driven without lamp");
endmodule
bind ibus_responder ibus_checker chk_u (.hclk, .hresetn, .ren_n, .ifc_n,
    .srq_oe_n, .remote_indicator, .talker_indicator, .listener_indicator,
    .srq_indicator, .keys_enable, .meas_abort, .meas_start, .output_cancel,
    .gate_reset, .display_blank, .errors_clear);
`default_nettype wire

// ### ibus_ctl_model.sv
// bus controller model driving the instrument bus pins
`timescale 1ns/1ps
`default_nettype none
module ibus_ctl_model (
    input  wire logic       hclk,  // sampling clock
    output var  logic [7:0] dio_n, // data lines, low true
    output var  logic       atn_n, // attention
    output var  logic       eoi_n, // end or identify
    output var  logic       dav_n, // data valid
    output var  logic       ren_n, // remote enable
    output var  logic       ifc_n  // interface clear
);
    // ************************************************
    // pin drivers
    // ************************************************
    // lines are pulled up, so a released line reads high
    initial begin
        dio_n = 8'hFF;
        {atn_n, eoi_n, dav_n, ren_n, ifc_n} = 5'h1F;
    end

    // byte held well past the sync delay, then released
    task automatic send(logic [7:0] b, logic a, logic e);
        @(posedge hclk);
        dio_n <= ~b;
        atn_n <= ~a;
        eoi_n <= ~e;
        @(posedge hclk);
        dav_n <= 1'b0;
        repeat (6) @(posedge hclk);
        dav_n <= 1'b1;
        @(posedge hclk);
        dio_n <= 8'hFF;
        atn_n <= 1'b1;
        eoi_n <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask

    task automatic set_ren(logic on);
        @(posedge hclk);
        ren_n <= ~on;
        repeat (8) @(posedge hclk);
    endtask

    task automatic pulse_ifc;
        @(posedge hclk);
        ifc_n <= 1'b0;
        repeat (8) @(posedge hclk);
        ifc_n <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// ### ibus_defines.vh
// constants for the instrument bus command responder
`ifndef IBUS_DEFINES_VH
`define IBUS_DEFINES_VH

// register byte offsets
`define REG_STATUS   8'h00
`define REG_ADDR     8'h04
`define REG_EVENT    8'h08
`define REG_RXDATA   8'h0C
`define REG_TXDATA   8'h10
`define REG_STB      8'h14
`define REG_SRQMASK  8'h18

// reset values
`define ADDR_RESET   5'h03
`define TX_RESET     8'h00
`define STB_RESET    8'h00
`define MASK_RESET   8'h00

// status register fields
`define ST_REMOTE    0
`define ST_LOCKOUT   1
`define ST_LISTEN    2
`define ST_TALK      3
`define ST_SPOLL     4
`define ST_SRQ       5

// event register fields
`define EV_CLEAR     0
`define EV_TRIGGER   1
`define EV_BYTE      2
`define EV_LAST      3
`define EV_LOCAL     4
`define EV_WIDTH     5

// rx data field holding the end-or-identify mark
`define RX_LAST      8

// service request bit of the status byte, never a condition
`define STB_RQS      6

// interface command codes, parity bit stripped
`define CMD_NULL     7'h00
`define CMD_GTL      7'h01
`define CMD_SDC      7'h04
`define CMD_GET      7'h08
`define CMD_LLO      7'h11
`define CMD_DCL      7'h14
`define CMD_SPE      7'h18
`define CMD_SPD      7'h19
`define CMD_UNL      7'h3F
`define CMD_UNT      7'h5F
`define GRP_LISTEN   2'b01
`define GRP_TALK     2'b10

`endif

// ### ibus_responder.v
// interface command responder with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ibus_defines.vh"

module ibus_responder (
    input  wire        hclk,         // system clock, 50 MHz
    input  wire        hresetn,      // async reset, active low
    input  wire        hsel,         // slave select
    input  wire [7:0]  haddr,        // byte address
    input  wire [1:0]  htrans,       // transfer type
    input  wire        hwrite,       // write when high
    input  wire [2:0]  hsize,        // transfer size, word only
    input  wire [31:0] hwdata,       // write data
    input  wire        hready,       // bus ready in
    output reg  [31:0] hrdata,       // read data
    output reg         hreadyout,    // always ready
    output reg         hresp,        // always okay
    input  wire [7:0]  dio_n,        // bus data lines, low true
    input  wire        atn_n,        // attention, low true
    input  wire        eoi_n,        // end or identify, low true
    input  wire        ren_n,        // remote enable, low true
    input  wire        ifc_n,        // interface clear, low true
    input  wire        dav_n,        // data valid, low true
    input  wire        local_key,    // front panel reset/local key
    output reg  [7:0]  dio_out_n,    // data driven while talking
    output reg         dio_oe_n,     // low while driving data
    output reg         srq_oe_n,     // low pulls service request
    output reg         remote_indicator,   // remote state lamp
    output reg         talker_indicator,   // addressed to talk
    output reg         listener_indicator, // addressed to listen
    output reg         srq_indicator,      // service request pending
    output reg         keys_enable,  // front panel keys usable
    output reg         meas_abort,   // pulse: abort measurement
    output reg         meas_start,   // pulse: start measurement
    output reg         output_cancel,// pulse: drop pending output
    output reg         gate_reset,   // pulse: reset the gate
    output reg         display_blank,// pulse: clear display
    output reg         errors_clear  // pulse: clear errors 1.0-4.4
);

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    reg [13:0] sync1_q;
    reg [13:0] sync2_q;
    reg        dav_d1_q;
    reg        key_d1_q;

    // the first stage is read by the second only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q  <= 14'h0000;
            sync2_q  <= 14'h0000;
            dav_d1_q <= 1'b0;
            key_d1_q <= 1'b0;
        end else begin
            sync1_q  <= {local_key, ~dav_n, ~ifc_n, ~ren_n, ~eoi_n,
                         ~atn_n, ~dio_n};
            sync2_q  <= sync1_q;
            dav_d1_q <= sync2_q[12];
            key_d1_q <= sync2_q[13];
        end
    end

    wire [7:0] bus_byte = sync2_q[7:0];
    wire       atn      = sync2_q[8];
    wire       eoi      = sync2_q[9];
    wire       ren      = sync2_q[10];
    wire       ifc      = sync2_q[11];
    wire       dav_rise = sync2_q[12] & ~dav_d1_q;
    wire       key_rise = sync2_q[13] & ~key_d1_q;
    wire [6:0] cmd      = bus_byte[6:0];  // parity bit ignored

    // ********************************************************
    // interface state flags
    // ********************************************************
    reg       remote_q;
    reg       lockout_q;
    reg       listen_q;
    reg       talk_q;
    reg       spoll_q;
    reg [4:0] my_addr_q;
    reg [7:0] tx_q;
    reg [7:0] stb_q;
    reg [7:0] mask_q;

    wire cmd_byte  = dav_rise & atn;
    wire data_byte = dav_rise & ~atn & listen_q;
    wire is_lad    = cmd[6:5] == `GRP_LISTEN && cmd != `CMD_UNL;
    wire is_tad    = cmd[6:5] == `GRP_TALK && cmd != `CMD_UNT;
    wire addr_hit  = cmd[4:0] == my_addr_q;
    wire do_dcl    = cmd_byte & (cmd == `CMD_DCL
                     | (cmd == `CMD_SDC & listen_q));
    wire do_get    = cmd_byte & cmd == `CMD_GET & listen_q;
    wire do_gtl    = cmd_byte & cmd == `CMD_GTL & listen_q;
    // key press honoured as local unless in remote with lockout
    wire do_key    = key_rise & ~(remote_q & lockout_q);
    wire srq_cond  = |(stb_q & mask_q & ~(8'h01 << `STB_RQS));

    // addressing, remote and poll state; the null command
    // falls through untouched
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_q  <= 1'b0;
            lockout_q <= 1'b0;
            listen_q  <= 1'b0;
            talk_q    <= 1'b0;
            spoll_q   <= 1'b0;
        end else begin
            if (!ren) begin
                remote_q  <= 1'b0;
                lockout_q <= 1'b0;
            end else if (do_gtl || do_key) begin
                remote_q  <= 1'b0;
            end else if (!remote_q) begin
                remote_q  <= 1'b1;
            end
            if (ren && cmd_byte && cmd == `CMD_LLO && remote_q) begin
                lockout_q <= 1'b1;
            end
            if (ifc) begin
                listen_q <= 1'b0;
                talk_q   <= 1'b0;
                spoll_q  <= 1'b0;
            end else if (cmd_byte) begin
                if (cmd == `CMD_UNL) begin
                    listen_q <= 1'b0;
                end
                if (is_lad && addr_hit) begin
                    listen_q <= 1'b1;
                end
                if (cmd == `CMD_UNT || (is_tad && !addr_hit)) begin
                    talk_q <= 1'b0;
                end
                if (is_tad && addr_hit) begin
                    talk_q <= 1'b1;
                end
                if (cmd == `CMD_SPE) begin
                    spoll_q <= 1'b1;
                end
                if (cmd == `CMD_SPD) begin
                    spoll_q <= 1'b0;
                end
            end
        end
    end

    // ********************************************************
    // device actions and bus outputs
    // ********************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_abort    <= 1'b0;
            meas_start    <= 1'b0;
            output_cancel <= 1'b0;
            gate_reset    <= 1'b0;
            display_blank <= 1'b0;
            errors_clear  <= 1'b0;
        end else begin
            meas_abort    <= do_dcl | do_get;
            meas_start    <= do_get;
            output_cancel <= do_dcl;
            gate_reset    <= do_dcl;
            display_blank <= do_dcl;
            errors_clear  <= do_dcl;
        end
    end

    // talker drives the poll byte or device data; idle after clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dio_out_n          <= 8'hFF;
            dio_oe_n           <= 1'b1;
            srq_oe_n           <= 1'b1;
            remote_indicator   <= 1'b0;
            talker_indicator   <= 1'b0;
            listener_indicator <= 1'b0;
            srq_indicator      <= 1'b0;
            keys_enable        <= 1'b1;
        end else begin
            dio_oe_n  <= ~(talk_q & ~atn & ~ifc);
            if (spoll_q) begin
                dio_out_n <= ~(stb_q | {1'b0, srq_cond, 6'h00});
            end else begin
                dio_out_n <= ~tx_q;
            end
            srq_oe_n           <= ~srq_cond;
            remote_indicator   <= remote_q;
            talker_indicator   <= talk_q;
            listener_indicator <= listen_q;
            srq_indicator      <= srq_cond;
            keys_enable        <= ~remote_q;
        end
    end

    // ********************************************************
    // received data capture
    // ********************************************************
    reg [8:0] rx_q;

    // end-or-identify only counts with attention false
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_q <= 9'h000;
        end else if (data_byte) begin
            rx_q <= {eoi, bus_byte};
        end
    end

    // ********************************************************
    // AHB-Lite slave
    // ********************************************************
    reg                 wr_pend_q;
    reg [7:0]           wr_addr_q;
    reg [`EV_WIDTH-1:0] event_q;

    wire take    = hsel & hready & htrans[1];
    wire wr_now  = wr_pend_q;
    wire [`EV_WIDTH-1:0] ev_set = {do_key, data_byte & eoi, data_byte,
                                   do_get, do_dcl};
    reg  [`EV_WIDTH-1:0] ev_clr;

    // write-one-to-clear, a new event in the same cycle wins
    always @* begin
        ev_clr = {`EV_WIDTH{1'b0}};
        if (wr_now && wr_addr_q == `REG_EVENT) begin
            ev_clr = hwdata[`EV_WIDTH-1:0];
        end
    end

    // address phase is latched, writes land in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            event_q   <= {`EV_WIDTH{1'b0}};
            my_addr_q <= `ADDR_RESET;
            tx_q      <= `TX_RESET;
            stb_q     <= `STB_RESET;
            mask_q    <= `MASK_RESET;
        end else begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= haddr;
            event_q   <= (event_q & ~ev_clr) | ev_set;
            if (wr_now) begin
                if (wr_addr_q == `REG_ADDR) begin
                    my_addr_q <= hwdata[4:0];
                end else if (wr_addr_q == `REG_TXDATA) begin
                    tx_q <= hwdata[7:0];
                end else if (wr_addr_q == `REG_STB) begin
                    stb_q <= hwdata[7:0];
                end else if (wr_addr_q == `REG_SRQMASK) begin
                    mask_q <= hwdata[7:0];
                end
            end
        end
    end

    // read data is formed at the address phase for a zero-wait answer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            if (haddr == `REG_STATUS) begin
                hrdata <= {26'h0000000, srq_cond, spoll_q, talk_q,
                           listen_q, lockout_q, remote_q};
            end else if (haddr == `REG_ADDR) begin
                hrdata <= {27'h0000000, my_addr_q};
            end else if (haddr == `REG_EVENT) begin
                hrdata <= {27'h0000000, event_q};
            end else if (haddr == `REG_RXDATA) begin
                hrdata <= {23'h000000, rx_q};
            end else if (haddr == `REG_TXDATA) begin
                hrdata <= {24'h000000, tx_q};
            end else if (haddr == `REG_STB) begin
                hrdata <= {24'h000000, stb_q};
            end else if (haddr == `REG_SRQMASK) begin
                hrdata <= {24'h000000, mask_q};
            end else begin
                hrdata <= 32'h00000000;               // unmapped reads zero
            end
        end
    end

    // size is word only; narrower sizes are treated as words
    wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the command responder
`timescale 1ns/1ps
`default_nettype none
`include "ibus_defines.vh"
module tb;
    logic        hclk;    // 50 MHz clock
    logic        hresetn; // reset, active low
    logic [7:0]  haddr;   // bus address
    logic [1:0]  htrans;  // transfer type
    logic        hwrite;  // write strobe
    logic [31:0] hwdata;  // write data
    logic        key;     // panel key
    logic [31:0] rv;      // last read word
    wire  [31:0] hrdata;  // read data
    wire         rdy;     // ready
    wire  [7:0]  dio_n;   // bus data
    wire  [7:0]  dout_n;  // talker byte
    wire  [4:0]  ln;      // atn eoi ren ifc dav
    wire  [3:0]  ind;     // remote talk listen srq
    wire         doe_n;   // data drive enable
    wire         soe_n;   // request pull enable
    wire         keys;    // keys usable
    wire  [5:0]  act;     // action pulses
    int          fails;   // mismatches
    int          checked; // comparisons

    // ************************************************
    // design, controller and clock
    // ************************************************
    ibus_responder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
        .hresp(), .dio_n(dio_n), .atn_n(ln[4]), .eoi_n(ln[3]),
        .ren_n(ln[2]), .ifc_n(ln[1]), .dav_n(ln[0]), .local_key(key),
        .dio_out_n(dout_n), .dio_oe_n(doe_n), .srq_oe_n(soe_n),
        .remote_indicator(ind[3]), .talker_indicator(ind[2]),
        .listener_indicator(ind[1]), .srq_indicator(ind[0]),
        .keys_enable(keys), .meas_abort(act[0]), .meas_start(act[1]),
        .output_cancel(act[2]), .gate_reset(act[3]),
        .display_blank(act[4]), .errors_clear(act[5]));
    ibus_ctl_model ctl_u (.hclk(hclk), .dio_n(dio_n), .atn_n(ln[4]),
        .eoi_n(ln[3]), .ren_n(ln[2]), .ifc_n(ln[1]), .dav_n(ln[0]));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one single transfer; read data taken at the data phase edge
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        rv = hrdata;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rv, e);
    endtask

    task automatic ev(logic [31:0] e);
        ahb(1'b0, `REG_EVENT, 32'h0);
        chk("event", rv & 32'h1F, e);
        ahb(1'b1, `REG_EVENT, 32'h1F);
    endtask

    task automatic cmd(logic [7:0] b);
        ctl_u.send(b, 1'b1, 1'b0);
    endtask

    // key held well past the pin synchroniser, then released
    task automatic press_key;
        @(posedge hclk);
        key <= 1'b1;
        repeat (6) @(posedge hclk);
        key <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_addr;
        rd(`REG_ADDR, 32'h3);
        rd(`REG_STATUS, 32'h0);
        rd(8'h1C, 32'h0);
        cmd(8'h23);
        chk("listener", ind[1], 32'h1);
        cmd(8'h43);
        rd(`REG_STATUS, 32'hC);
        cmd(8'h44);
        rd(`REG_STATUS, 32'h4);
        cmd(8'h3F);
        cmd(8'h24);
        rd(`REG_STATUS, 32'h0);
        ahb(1'b1, `REG_ADDR, 32'h5);
        rd(`REG_ADDR, 32'h5);
        cmd(8'h25);
        chk("new address", ind[1], 32'h1);
        cmd(8'h3F);
        ahb(1'b1, `REG_ADDR, 32'h3);
        $display("addressing test done");
    endtask

    task automatic t_remote;
        ctl_u.set_ren(1'b1);
        rd(`REG_STATUS, 32'h1);
        chk("keys", keys, 32'h0);
        cmd(8'h11);
        rd(`REG_STATUS, 32'h3);
        press_key;
        rd(`REG_STATUS, 32'h3);
        rd(`REG_EVENT, 32'h0);
        ctl_u.set_ren(1'b0);
        rd(`REG_STATUS, 32'h0);
        press_key;
        rd(`REG_EVENT, 32'h10);
        $display("remote test done");
    endtask

    task automatic t_trig;
        ahb(1'b1, `REG_EVENT, 32'h1F);
        cmd(8'h23);
        cmd(8'h08);
        ev(32'h2);
        cmd(8'h00);
        rd(`REG_STATUS, 32'h4);
        cmd(8'h14);
        ev(32'h1);
        cmd(8'h3F);
        cmd(8'h04);
        cmd(8'h08);
        ev(32'h0);
        cmd(8'h3F);
        cmd(8'h55);
        cmd(8'h23);
        cmd(8'h04);
        ev(32'h1);
        ctl_u.send(8'h41, 1'b0, 1'b1);
        rd(`REG_RXDATA, 32'h141);
        cmd(8'h00);
        rd(`REG_RXDATA, 32'h141);
        ctl_u.send(8'h5A, 1'b0, 1'b0);
        rd(`REG_RXDATA, 32'h05A);
        $display("trigger and data test done");
    endtask

    task automatic t_poll;
        ahb(1'b1, `REG_STB, 32'h05);
        ahb(1'b1, `REG_SRQMASK, 32'h01);
        ahb(1'b1, `REG_TXDATA, 32'h5A);
        chk("srq pull", soe_n, 32'h0);
        cmd(8'h3F);
        cmd(8'h35);
        cmd(8'h43);
        cmd(8'h18);
        rd(`REG_STATUS, 32'h38);
        chk("poll byte", dout_n, 32'hBA);
        chk("drive on", doe_n, 32'h0);
        chk("lamps", ind, 32'h5);
        cmd(8'h19);
        chk("data byte", dout_n, 32'hA5);
        cmd(8'h5F);
        rd(`REG_STATUS, 32'h20);
        cmd(8'h43);
        cmd(8'h23);
        ctl_u.pulse_ifc;
        rd(`REG_STATUS, 32'h20);
        chk("drive off", doe_n, 32'h1);
        $display("poll and clear test done");
    endtask

    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************
    // main sequence and watchdog
    // ************************************************
    initial begin
        hresetn = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        key = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_addr;
        t_remote;
        t_trig;
        t_poll;
        print_verdict;
    end

    // whole run needs far fewer than 10000 cycles
    initial begin
        #200000;
        fails++;
        print_verdict;
    end
endmodule
`default_nettype wire
